// ===== verilog/prescaler_pkg.sv
// constants for the shared prescaler, timer and watchdog postscaler block
// assumes one 10 MHz clock (one quarter phase per cycle) and a word-wide AHB-Lite slave port
//
// Function
// - timer increments three to seven phase clocks after a qualifying input change
// - one 8-bit counter divides either timer or watchdog, other runs undivided
// - assignment bit and three-bit ratio sit in option bits three down to zero
// - any timer write clears the counter while assigned to the timer
// - watchdog clear resets watchdog count and counter while assigned to watchdog
// - the shared counter can be neither read nor written by software
// - every reset leaves the shared counter at zero
// - assignment may change any time, new setting applies from the option write
// - watchdog disabled only by its configuration bit, runs from own oscillator
// - configuration word bit two set enables watchdog, clear disables it
// - counter output toward the timer is sampled on the second and fourth phases
// - assignment bit clear gives timer ratios from 1:2 up to 1:256
// - watchdog assignment gives postscaler ratios up to 1:128

package prescaler_pkg;

    // ----------------------------------------------------------------
    // register map, byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_OPTION = 8'h00;
    localparam logic [7:0] OFS_TIMER = 8'h04;
    localparam logic [7:0] OFS_COMMAND = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_CONFIG = 8'h10;
    localparam logic [7:0] OFS_NONE = 8'hff;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int OPT_SRC_BIT = 5;
    localparam int OPT_EDGE_BIT = 4;
    localparam int OPT_ASSIGN_BIT = 3;
    localparam int OPT_RATIO_LSB = 0;
    localparam int OPT_RATIO_W = 3;
    localparam int OPT_W = 6;
    localparam int CFG_W = 12;
    localparam int CFG_WDT_EN_BIT = 2;
    localparam int CMD_CLEAR_BIT = 0;
    localparam int STS_TIMEOUT_BIT = 0;
    localparam int STS_WDEN_BIT = 1;
    localparam int STS_CFGOK_BIT = 2;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [5:0] OPTION_RST = 6'h3f;
    localparam logic [7:0] TIMER_RST = 8'h00;
    localparam logic [7:0] PRESCALE_RST = 8'h00;

    // ----------------------------------------------------------------
    // quarter phases, one clock cycle each
    // ----------------------------------------------------------------
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

endpackage : prescaler_pkg

// ===== verilog/sync_three.sv
// three-stage synchroniser for one asynchronous pin
// assumes the pin is unrelated to mclk; only stages two and three leave the module
`timescale 1ns/1ns

module sync_three
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic pinIn,
    output logic stageTwo,
    output logic stageThree
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    always_comb
    begin
        st_nxt.s1 = pinIn;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (reset)
        begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge mclk)
    begin
        st_r <= st_nxt;
    end

    assign stageTwo = st_r.s2;
    assign stageThree = st_r.s3;

endmodule : sync_three

// ===== verilog/shared_prescaler_timer_watchdog.sv
// shared 8-bit prescaler in front of the timer or behind the watchdog base period
// assumes a watchdog base tick pulse already on mclk and a single AHB-Lite master
`timescale 1ns/1ns

module shared_prescaler_timer_watchdog
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic timerExtClockIn,
    input wire logic watchdogBaseTick,
    input wire logic [11:0] cfgWord,
    output logic watchdogTimeout,
    output logic watchdogClearPulse,
    output logic [7:0] timerCount
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] phase;
        logic [5:0] option;
        logic [7:0] timerCountReg;
        logic [7:0] prescale;
        logic extLevel;
        logic incPending;
        logic [11:0] cfgLatch;
        logic cfgLoaded;
        logic timeoutSeen;
        logic wdTimeout;
        logic wdClear;
        logic dpValid;
        logic dpWrite;
        logic [7:0] dpAddr;
        logic [31:0] rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic extTwo;
    logic extThree;
    logic extMode;
    logic edgeFall;
    logic assignWd;
    logic [2:0] scalerRatio;
    logic [7:0] maskWd;
    logic [7:0] maskTmr;
    logic extQualify;
    logic instrTick;
    logic sampleEdge;
    logic timerSrcEvent;
    logic timerPre;
    logic countPre;
    logic wdOut;
    logic timerIncEn;
    logic wdEnabled;
    logic wrOption;
    logic wrTimer;
    logic wrCommand;
    logic wrStatus;
    logic takeAddr;
    logic [8:0] wideWd;
    logic [8:0] wideTmr;

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    sync_three extSync
    (
        .mclk(mclk),
        .reset(reset),
        .pinIn(timerExtClockIn),
        .stageTwo(extTwo),
        .stageThree(extThree)
    );

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    // the prescaler has no address: it can only be cleared as a side effect
    function automatic logic [31:0] readWord(input state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (s.dpAddr)
            prescaler_pkg::OFS_OPTION: w[5:0] = s.option;
            prescaler_pkg::OFS_TIMER: w[7:0] = s.timerCountReg;
            prescaler_pkg::OFS_STATUS:
            begin
                w[prescaler_pkg::STS_TIMEOUT_BIT] = s.timeoutSeen;
                w[prescaler_pkg::STS_WDEN_BIT] = s.cfgLatch[prescaler_pkg::CFG_WDT_EN_BIT];
                w[prescaler_pkg::STS_CFGOK_BIT] = s.cfgLoaded;
            end
            prescaler_pkg::OFS_CONFIG: w[11:0] = s.cfgLatch;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction : readWord

    // ----------------------------------------------------------------
    // decode of the option setting
    // ----------------------------------------------------------------
    assign extMode = st_r.option[prescaler_pkg::OPT_SRC_BIT];
    assign edgeFall = st_r.option[prescaler_pkg::OPT_EDGE_BIT];
    assign assignWd = st_r.option[prescaler_pkg::OPT_ASSIGN_BIT];
    assign scalerRatio = st_r.option[prescaler_pkg::OPT_RATIO_LSB +: prescaler_pkg::OPT_RATIO_W];
    // watchdog divides by 2^n, timer by 2^(n+1): tap bit n-1 or bit n
    assign wideWd = (9'h001 << scalerRatio) - 9'h001;
    assign wideTmr = (9'h002 << scalerRatio) - 9'h001;
    assign maskWd = wideWd[7:0];
    assign maskTmr = wideTmr[7:0];

    // ----------------------------------------------------------------
    // event sources
    // ----------------------------------------------------------------
    // a change to the level picked by the edge bit is accepted once stages two and three agree on it
    assign extQualify = (extTwo == extThree) && (extThree != st_r.extLevel)
        && (extThree == !edgeFall);
    assign instrTick = (st_r.phase == prescaler_pkg::PH_Q4);
    assign sampleEdge = (st_r.phase == prescaler_pkg::PH_Q2)
        || (st_r.phase == prescaler_pkg::PH_Q4);
    assign timerSrcEvent = extMode ? extQualify : instrTick;

    // ----------------------------------------------------------------
    // prescaler routing
    // ----------------------------------------------------------------
    always_comb
    begin
        if (assignWd)
        begin
            timerPre = timerSrcEvent;
            countPre = watchdogBaseTick;
            wdOut = watchdogBaseTick && ((st_r.prescale & maskWd) == maskWd);
        end
        else
        begin
            // rising edge of tap bit n: low bits all ones, tap bit still zero
            timerPre = timerSrcEvent
                && ((st_r.prescale & maskTmr) == (maskTmr >> 1));
            countPre = timerSrcEvent;
            wdOut = watchdogBaseTick;
        end
    end

    // one counter, one source at a time; the other path bypasses it
    assign timerIncEn = sampleEdge && (st_r.incPending || timerPre);
    // only the configuration bit can switch the watchdog off
    assign wdEnabled = st_r.cfgLoaded && st_r.cfgLatch[prescaler_pkg::CFG_WDT_EN_BIT];

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign takeAddr = hsel && hready && htrans[1];
    assign wrOption = st_r.dpValid && st_r.dpWrite && (st_r.dpAddr == prescaler_pkg::OFS_OPTION);
    assign wrTimer = st_r.dpValid && st_r.dpWrite && (st_r.dpAddr == prescaler_pkg::OFS_TIMER);
    assign wrCommand = st_r.dpValid && st_r.dpWrite
        && (st_r.dpAddr == prescaler_pkg::OFS_COMMAND);
    assign wrStatus = st_r.dpValid && st_r.dpWrite && (st_r.dpAddr == prescaler_pkg::OFS_STATUS);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.phase = st_r.phase + 2'h1;
        st_nxt.wdTimeout = 1'b0;
        st_nxt.wdClear = 1'b0;
        st_nxt.rdata = 32'h0000_0000;

        // strap is caught one cycle after release, never inside reset
        if (!st_r.cfgLoaded)
        begin
            st_nxt.cfgLatch = cfgWord;
            st_nxt.cfgLoaded = 1'b1;
        end

        if (extTwo == extThree)
        begin
            st_nxt.extLevel = extThree;
        end

        if (countPre)
        begin
            st_nxt.prescale = st_r.prescale + 8'h01;
        end

        // sampled output waits for the next Q2 or Q4 edge
        st_nxt.incPending = (st_r.incPending || timerPre) && !sampleEdge;
        if (timerIncEn)
        begin
            st_nxt.timerCountReg = st_r.timerCountReg + 8'h01;
        end

        st_nxt.wdTimeout = wdOut && wdEnabled;

        if (wrOption)
        begin
            st_nxt.option = hwdata[5:0];
        end

        if (wrTimer)
        begin
            // the write wins over a same-cycle increment
            st_nxt.timerCountReg = hwdata[7:0];
            st_nxt.incPending = 1'b0;
            if (!assignWd)
            begin
                st_nxt.prescale = prescaler_pkg::PRESCALE_RST;
            end
        end

        if (wrCommand && hwdata[prescaler_pkg::CMD_CLEAR_BIT])
        begin
            st_nxt.wdClear = 1'b1;
            if (assignWd)
            begin
                st_nxt.prescale = prescaler_pkg::PRESCALE_RST;
            end
        end

        // set wins over a write-one clear in the same cycle
        st_nxt.timeoutSeen = (st_r.timeoutSeen
            && !(wrStatus && hwdata[prescaler_pkg::STS_TIMEOUT_BIT])) || st_nxt.wdTimeout;

        st_nxt.dpValid = takeAddr;
        st_nxt.dpWrite = hwrite;
        st_nxt.dpAddr = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : prescaler_pkg::OFS_NONE;
        if (takeAddr && !hwrite)
        begin
            // read the post-write view so a read right after a write is coherent
            st_nxt.rdata = readWord(st_nxt);
        end

        if (reset)
        begin
            st_nxt = '0;
            st_nxt.phase = prescaler_pkg::PH_Q1;
            st_nxt.option = prescaler_pkg::OPTION_RST;
            st_nxt.timerCountReg = prescaler_pkg::TIMER_RST;
            st_nxt.prescale = prescaler_pkg::PRESCALE_RST;
        end
    end

    always_ff @(posedge mclk)
    begin
        st_r <= st_nxt;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // zero wait states; every transfer, mapped or not, ends OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_r.rdata;
    assign watchdogTimeout = st_r.wdTimeout;
    assign watchdogClearPulse = st_r.wdClear;
    assign timerCount = st_r.timerCountReg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence extSeen;
        extQualify && extMode && assignWd && !wrTimer;
    endsequence

    sequence timerCleared;
        wrTimer && !assignWd;
    endsequence

    sequence wdCleared;
        wrCommand && hwdata[prescaler_pkg::CMD_CLEAR_BIT] && assignWd;
    endsequence

    chk_ext_delay: assert property (extSeen |-> ##[0:1] timerIncEn)
        else $error("external edge did not reach the timer in time");

    chk_inc_phase: assert property (timerIncEn |-> (st_r.phase == prescaler_pkg::PH_Q2
        || st_r.phase == prescaler_pkg::PH_Q4))
        else $error("timer incremented outside Q2 or Q4");

    chk_wdt_undivided: assert property (!assignWd && watchdogBaseTick && wdEnabled
        && !wrOption |=> watchdogTimeout)
        else $error("watchdog not undivided while counter serves the timer");

    chk_counter_frozen: assert property (assignWd && !watchdogBaseTick && !wrCommand
        && !wrOption |=> $stable(st_r.prescale))
        else $error("counter moved without a watchdog tick");

    chk_option_apply: assert property (wrOption |=> st_r.option == $past(hwdata[5:0])
        ##1 assignWd == st_r.option[prescaler_pkg::OPT_ASSIGN_BIT])
        else $error("option write not applied");

    chk_tmr_clear: assert property (timerCleared |=> st_r.prescale == 8'h00
        && st_r.timerCountReg == $past(hwdata[7:0]))
        else $error("timer write did not clear the counter");

    chk_wdt_clear: assert property (wdCleared |=> st_r.prescale == 8'h00
        && watchdogClearPulse ##1 !watchdogClearPulse)
        else $error("watchdog clear did not clear the counter");

    chk_reset_zero: assert property ($fell(reset) |-> st_r.prescale == 8'h00
        && st_r.option == prescaler_pkg::OPTION_RST)
        else $error("counter not zero after reset");

    chk_cfg_enable: assert property (watchdogTimeout |-> st_r.cfgLatch[2]
        && st_r.cfgLoaded)
        else $error("watchdog fired while disabled by configuration");

    chk_wdt_ratio: assert property (assignWd && scalerRatio == 3'h7 && watchdogBaseTick
        && st_r.prescale[6:0] != 7'h7f |=> !watchdogTimeout)
        else $error("watchdog postscaler fired early at 1:128");

    chk_tmr_ratio: assert property (!assignWd && !extMode && scalerRatio == 3'h0
        && timerPre |-> st_r.prescale[0] == 1'b0)
        else $error("timer prescale tap wrong for ratio 1:2");

endmodule : shared_prescaler_timer_watchdog

// ===== test/cpu_core_model.sv
// cpu core model: single word transfers on the AHB-Lite port of the block
// assumes one slave whose hreadyout comes back as hready
`timescale 1ns/1ns

module cpu_core_model
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic start,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic [31:0] rdata,
    output logic done
);
    logic [1:0] st;

    assign hsize = 3'h2;

    initial
    begin
        st = 2'h0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        done = 1'b0;
    end

    // --------------------------------
    // address phase held until hready, then data phase held until hready
    // --------------------------------
    always @(posedge mclk)
    begin
        done <= 1'b0;
        if (reset)
        begin
            st <= 2'h0;
            hsel <= 1'b0;
            htrans <= 2'h0;
        end
        else if (st == 2'h0 && start)
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            haddr <= {24'h0, addr};
            hwrite <= wr;
            st <= 2'h1;
        end
        else if (st == 2'h1 && hready)
        begin
            htrans <= 2'h0;
            hwdata <= wr ? wdata : ~hwdata;
            st <= 2'h2;
        end
        else if (st == 2'h2 && hready)
        begin
            rdata <= hrdata;
            done <= 1'b1;
            hsel <= 1'b0;
            // released lines show the inverse, never a stale copy
            haddr <= ~haddr;
            hwdata <= ~hwdata;
            st <= 2'h0;
        end
    end
endmodule : cpu_core_model

// ===== test/shared_prescaler_timer_watchdog_bench.sv
// bench for the shared prescaler, timer and watchdog block
// assumes the design, its package and the cpu core model; 10 MHz mclk
`timescale 1ns/1ns

module shared_prescaler_timer_watchdog_bench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic hsel, hwrite, hreadyout, hresp, cDone, watchdogTimeout, watchdogClearPulse;
    logic cStart = 1'b0, cWr = 1'b0, timerExtClockIn = 1'b0, watchdogBaseTick = 1'b0;
    logic [31:0] haddr, hwdata, hrdata, cRdata, q;
    logic [31:0] cData = 32'h0;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] cAddr = 8'h0, timerCount, v;
    logic [11:0] cfgWord = 12'h004;
    int tmoSeen = 0, clrSeen = 0, cyc = 0, fail_count = 0, samples_checked = 0, t0, r;

    always #50 mclk = ~mclk;

    shared_prescaler_timer_watchdog uut (.mclk(mclk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .timerExtClockIn(timerExtClockIn), .watchdogBaseTick(watchdogBaseTick),
        .cfgWord(cfgWord), .watchdogTimeout(watchdogTimeout),
        .watchdogClearPulse(watchdogClearPulse), .timerCount(timerCount));

    cpu_core_model core (.mclk(mclk), .reset(reset), .start(cStart), .wr(cWr),
        .addr(cAddr), .wdata(cData), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .rdata(cRdata), .done(cDone));

    // --------------------------------
    // pulse counters and hang limit
    // --------------------------------
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (watchdogTimeout === 1'b1)
            tmoSeen <= tmoSeen + 1;
        if (watchdogClearPulse === 1'b1)
            clrSeen <= clrSeen + 1;
        if (cyc == 40000)
        begin
            fail_count++;
            final_report();
        end
    end

    // --------------------------------
    // tasks and expectations
    // --------------------------------
    function automatic int tmr_period(input logic a, input int n);
        return a ? 4 : 4 << (n + 1);
    endfunction : tmr_period

    function automatic int wd_ratio(input int n);
        return 1 << n;
    endfunction : wd_ratio

    task automatic final_report();
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic do_reset();
        reset <= 1'b1;
        tick(20);
        reset <= 1'b0;
        tick(2);
    endtask : do_reset

    // the model starts on a one-cycle request; done is looked at off the edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cStart <= 1'b1;
        cWr <= w;
        cAddr <= a;
        cData <= d;
        tick(1);
        cStart <= 1'b0;
        while (cDone !== 1'b1 && k < 20)
        begin
            @(negedge mclk);
            k++;
        end
        check(32'(cDone), 32'h1);
        check(32'(hresp), 32'h0);
        q = cRdata;
        tick(1);
    endtask : bus

    task automatic wd_count(input int n, input int exp);
        int s;
        s = tmoSeen;
        repeat (n)
        begin
            watchdogBaseTick <= 1'b1;
            tick(1);
            watchdogBaseTick <= 1'b0;
            tick(3);
        end
        check(32'(tmoSeen - s), 32'(exp));
    endtask : wd_count

    // first change only aligns; the second interval is the measured one
    task automatic period(input int exp);
        logic [7:0] s;
        int k;
        for (int i = 0; i < 2; i++)
        begin
            s = timerCount;
            k = 0;
            while (timerCount === s && k < 3000)
            begin
                @(negedge mclk);
                k++;
            end
        end
        check(32'(k), 32'(exp));
        tick(1);
    endtask : period

    // k counts negedges, one per clock period since the pin change
    task automatic pin_delay(input logic lvl, input logic counts);
        logic [7:0] s;
        int k;
        s = timerCount;
        timerExtClockIn <= lvl;
        k = 0;
        while (timerCount === s && k < 9)
        begin
            @(negedge mclk);
            k++;
        end
        if (counts)
            check(32'(k >= 3 && k <= 7), 32'h1);
        check(32'(timerCount), 32'(s + 8'(counts)));
        tick(1 + $urandom % 4);
    endtask : pin_delay

    task automatic pulse();
        timerExtClockIn <= 1'b1;
        tick(10);
        timerExtClockIn <= 1'b0;
        tick(10);
    endtask : pulse

    // --------------------------------
    // main sequence
    // --------------------------------
    initial
    begin
        void'($urandom(32'h2ac38da7));
        cfgWord = 12'($urandom) | 12'h004;
        do_reset();
        check(32'(timerCount), 32'h0);
        bus(1'b0, prescaler_pkg::OFS_OPTION, 32'h0);
        check(q, 32'h3f);
        bus(1'b0, 8'h14, 32'h0);
        check(q, 32'h0);
        wd_count(wd_ratio(7) - 1, 0);
        wd_count(1, 1);
        bus(1'b0, prescaler_pkg::OFS_STATUS, 32'h0);
        check(q & 32'h7, 32'h7);
        $display("test 1 done");
        for (int n = 0; n < 8; n++)
        begin
            bus(1'b1, prescaler_pkg::OFS_OPTION, 32'(8'h28 + n));
            // counter still holds 2^(n-1) from the previous ratio
            r = $urandom % wd_ratio(n);
            wd_count(r, (n > 0 && r >= wd_ratio(n) / 2) ? 1 : 0);
            t0 = clrSeen;
            bus(1'b1, prescaler_pkg::OFS_COMMAND, 32'h1);
            tick(2);
            check(32'(clrSeen - t0), 32'h1);
            wd_count(wd_ratio(n) - 1, 0);
            wd_count(1, 1);
        end
        $display("test 2 done");
        bus(1'b1, prescaler_pkg::OFS_COMMAND, 32'h1);
        for (int n = 0; n < 8; n++)
        begin
            bus(1'b1, prescaler_pkg::OFS_OPTION, 32'(n));
            bus(1'b1, prescaler_pkg::OFS_TIMER, $urandom);
            period(tmr_period(1'b0, n));
        end
        wd_count(3, 3);
        bus(1'b1, prescaler_pkg::OFS_COMMAND, 32'h1);
        bus(1'b1, prescaler_pkg::OFS_TIMER, 32'h0);
        bus(1'b1, prescaler_pkg::OFS_OPTION, 32'h0f);
        bus(1'b1, prescaler_pkg::OFS_COMMAND, 32'h1);
        bus(1'b1, prescaler_pkg::OFS_OPTION, 32'h0a);
        period(tmr_period(1'b1, 2));
        $display("test 3 done");
        for (int e = 0; e < 2; e++)
        begin
            bus(1'b1, prescaler_pkg::OFS_OPTION, 32'(8'h28 + 16 * e));
            repeat (5)
            begin
                pin_delay(1'b1, e == 0);
                pin_delay(1'b0, e == 1);
            end
        end
        $display("test 4 done");
        bus(1'b1, prescaler_pkg::OFS_COMMAND, 32'h1);
        bus(1'b1, prescaler_pkg::OFS_OPTION, 32'h20);
        v = 8'($urandom);
        pulse();
        bus(1'b1, prescaler_pkg::OFS_TIMER, 32'(v));
        // a cleared 1:2 counter passes the first edge, then holds the second
        pulse();
        check(32'(timerCount), 32'(v + 8'h1));
        pulse();
        check(32'(timerCount), 32'(v + 8'h1));
        $display("test 5 done");
        // a watchdog left disabled by the strap must never time out
        cfgWord <= 12'($urandom) & 12'hffb;
        do_reset();
        check(32'(timerCount), 32'h0);
        bus(1'b0, prescaler_pkg::OFS_STATUS, 32'h0);
        check(q & 32'h2, 32'h0);
        bus(1'b1, prescaler_pkg::OFS_COMMAND, 32'h1);
        bus(1'b1, prescaler_pkg::OFS_OPTION, 32'h20);
        wd_count(4, 0);
        $display("test 6 done");
        final_report();
    end
endmodule : shared_prescaler_timer_watchdog_bench
